// ### rtl/aogc_pkg.sv
// Shared constants, register indices and carrier types of the calibration bank
package aogc_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int DATA_W = 32;
  localparam int BYTE_W = 8;
  localparam int OFF_W = 15;
  localparam int GAIN_W = 9;
  localparam int IDX_W = 8;
  // Gain of 256 is unity, so the product is shifted down by eight
  localparam int GAIN_SHIFT = 8;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_X_OFF_LO = 8'h2a;
  localparam logic [IDX_W-1:0] IDX_X_OFF_HI = 8'h2b;
  localparam logic [IDX_W-1:0] IDX_Y_OFF_LO = 8'h2c;
  localparam logic [IDX_W-1:0] IDX_Y_OFF_HI = 8'h2d;
  localparam logic [IDX_W-1:0] IDX_Z_OFF_LO = 8'h2e;
  localparam logic [IDX_W-1:0] IDX_Z_OFF_HI = 8'h2f;
  localparam logic [IDX_W-1:0] IDX_X_GAIN_LO = 8'h30;
  localparam logic [IDX_W-1:0] IDX_Y_GAIN_LO = 8'h31;
  localparam logic [IDX_W-1:0] IDX_Z_GAIN_LO = 8'h32;
  localparam logic [IDX_W-1:0] IDX_CAL_CTRL = 8'h40;
  localparam logic [IDX_W-1:0] IDX_OUT_X = 8'h41;
  localparam logic [IDX_W-1:0] IDX_OUT_Y = 8'h42;
  localparam logic [IDX_W-1:0] IDX_OUT_Z = 8'h43;

  // ----------------------------------------------------------------
  // Field positions inside the shared high byte, the control register and the bus address
  // ----------------------------------------------------------------
  localparam int HI_OFF_BITS = 7;
  localparam int GAIN_MSB_POS = 7;
  localparam int RELOAD_BIT = 0;
  localparam int ADDR_LSB = 2;

  // Calibration set of all three axes
  typedef struct packed {
    logic [OFF_W-1:0] x_off;
    logic [OFF_W-1:0] y_off;
    logic [OFF_W-1:0] z_off;
    logic [GAIN_W-1:0] x_gain;
    logic [GAIN_W-1:0] y_gain;
    logic [GAIN_W-1:0] z_gain;
  } aogc_cal_t;

endpackage : aogc_pkg

// ### rtl/aogc_axis_cal.sv
// One axis of the calibration path: offset add, gain scale, saturate
`timescale 1ns/1ps

module aogc_axis_cal #(
  parameter int IN_W = 14,
  parameter int OUT_W = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic in_valid,
  input wire logic signed [IN_W-1:0] in_data,
  input wire logic signed [aogc_pkg::OFF_W-1:0] offset,
  input wire logic [aogc_pkg::GAIN_W-1:0] gain,
  output logic out_valid,
  output logic signed [OUT_W-1:0] out_data
);

  localparam int SUM_W = ((IN_W > aogc_pkg::OFF_W) ? IN_W : aogc_pkg::OFF_W) + 1;
  localparam int PROD_W = SUM_W + aogc_pkg::GAIN_W + 1;
  localparam logic signed [PROD_W-1:0] SAT_HI = PROD_W'((64'sd1 <<< (OUT_W - 1)) - 64'sd1);
  localparam logic signed [PROD_W-1:0] SAT_LO = -SAT_HI - PROD_W'(64'sd1);

  // ----------------------------------------------------------------
  // Arithmetic
  // ----------------------------------------------------------------
  // Offset first, then gain; the extra sum bit keeps the add exact
  wire logic signed [SUM_W-1:0] sum = SUM_W'(in_data) + SUM_W'(offset);
  wire logic signed [PROD_W-1:0] gain_s = PROD_W'(signed'({1'b0, gain}));
  wire logic signed [PROD_W-1:0] prod = PROD_W'(sum) * gain_s;
  wire logic signed [PROD_W-1:0] scaled = prod >>> aogc_pkg::GAIN_SHIFT;
  // Clamp rather than wrap, so a large gain cannot flip the sign
  wire logic signed [OUT_W-1:0] next_out = (scaled > SAT_HI) ? OUT_W'(SAT_HI) :
                                           (scaled < SAT_LO) ? OUT_W'(SAT_LO) :
                                           OUT_W'(scaled);

  // Result register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      out_valid <= 1'b0;
      out_data <= '0;
    end else if (ce) begin
      out_valid <= in_valid;
      if (in_valid) out_data <= next_out;
    end
  end

endmodule : aogc_axis_cal

// ### rtl/aogc_top.sv
// APB calibration register bank feeding the three-axis sample path
`timescale 1ns/1ps

module aogc_top #(
  parameter int PADDR_W = 12,
  parameter int IN_W = 14,
  parameter int OUT_W = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic [aogc_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [aogc_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire aogc_pkg::aogc_cal_t factory_cal,
  input wire logic raw_valid,
  input wire logic signed [IN_W-1:0] raw_x,
  input wire logic signed [IN_W-1:0] raw_y,
  input wire logic signed [IN_W-1:0] raw_z,
  output logic out_valid,
  output logic signed [OUT_W-1:0] out_x,
  output logic signed [OUT_W-1:0] out_y,
  output logic signed [OUT_W-1:0] out_z
);

  localparam int IDX_HI = aogc_pkg::ADDR_LSB + aogc_pkg::IDX_W;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic ack_q;
  aogc_pkg::aogc_cal_t cal;
  aogc_pkg::aogc_cal_t next_cal;

  // Index comes from the word address; the lane bits and upper bits must be zero
  wire logic access = psel && penable;
  wire logic [aogc_pkg::IDX_W-1:0] reg_idx = paddr[IDX_HI-1:aogc_pkg::ADDR_LSB];
  wire logic addr_clean = (paddr[PADDR_W-1:IDX_HI] == '0) &&
                          (paddr[aogc_pkg::ADDR_LSB-1:0] == '0);
  wire logic hit_xol = addr_clean && (reg_idx == aogc_pkg::IDX_X_OFF_LO);
  wire logic hit_xoh = addr_clean && (reg_idx == aogc_pkg::IDX_X_OFF_HI);
  wire logic hit_yol = addr_clean && (reg_idx == aogc_pkg::IDX_Y_OFF_LO);
  wire logic hit_yoh = addr_clean && (reg_idx == aogc_pkg::IDX_Y_OFF_HI);
  wire logic hit_zol = addr_clean && (reg_idx == aogc_pkg::IDX_Z_OFF_LO);
  wire logic hit_zoh = addr_clean && (reg_idx == aogc_pkg::IDX_Z_OFF_HI);
  wire logic hit_xg = addr_clean && (reg_idx == aogc_pkg::IDX_X_GAIN_LO);
  wire logic hit_yg = addr_clean && (reg_idx == aogc_pkg::IDX_Y_GAIN_LO);
  wire logic hit_zg = addr_clean && (reg_idx == aogc_pkg::IDX_Z_GAIN_LO);
  wire logic hit_ctrl = addr_clean && (reg_idx == aogc_pkg::IDX_CAL_CTRL);
  wire logic hit_ox = addr_clean && (reg_idx == aogc_pkg::IDX_OUT_X);
  wire logic hit_oy = addr_clean && (reg_idx == aogc_pkg::IDX_OUT_Y);
  wire logic hit_oz = addr_clean && (reg_idx == aogc_pkg::IDX_OUT_Z);
  wire logic hit_cal = hit_xol || hit_xoh || hit_yol || hit_yoh || hit_zol ||
                       hit_zoh || hit_xg || hit_yg || hit_zg;
  wire logic mapped = hit_cal || hit_ctrl || hit_ox || hit_oy || hit_oz;

  // One wait state: read data is captured in the first access cycle.
  // ce enters pready so that a frozen block never completes a transfer.
  assign pready = access && ack_q && ce;
  assign pslverr = pready && !mapped;

  // Write fires only at the completing edge, low byte lane enabled
  wire logic wr_fire = pready && pwrite && mapped && pstrb[0];
  wire logic rd_cap = access && !ack_q && !pwrite && ce;
  wire logic [aogc_pkg::BYTE_W-1:0] wbyte = pwdata[aogc_pkg::BYTE_W-1:0];
  wire logic [aogc_pkg::HI_OFF_BITS-1:0] whi = pwdata[aogc_pkg::HI_OFF_BITS-1:0];
  wire logic wmsb = pwdata[aogc_pkg::GAIN_MSB_POS];
  // Reload restores the factory set without a full reset
  wire logic reload = wr_fire && hit_ctrl && pwdata[aogc_pkg::RELOAD_BIT];

  // Wait-state flag
  always_ff @(posedge clk) begin
    if (sys_rst) ack_q <= 1'b0;
    else if (ce) ack_q <= access && !ack_q;
  end

  // ----------------------------------------------------------------
  // Calibration registers
  // ----------------------------------------------------------------
  // Next calibration set; reload and writes never hit the same cycle
  always_comb begin
    next_cal = cal;
    if (reload) begin
      next_cal = factory_cal;
    end else if (wr_fire) begin
      if (hit_xol) next_cal.x_off[aogc_pkg::BYTE_W-1:0] = wbyte;
      if (hit_xoh) next_cal.x_off[aogc_pkg::OFF_W-1:aogc_pkg::BYTE_W] = whi;
      if (hit_yol) next_cal.y_off[aogc_pkg::BYTE_W-1:0] = wbyte;
      if (hit_yoh) next_cal.y_off[aogc_pkg::OFF_W-1:aogc_pkg::BYTE_W] = whi;
      // Z offset split over two bytes
      if (hit_zol) next_cal.z_off[aogc_pkg::BYTE_W-1:0] = wbyte;
      if (hit_zoh) next_cal.z_off[aogc_pkg::OFF_W-1:aogc_pkg::BYTE_W] = whi;
      // X gain top bit rides in the offset high byte
      if (hit_xoh) next_cal.x_gain[aogc_pkg::GAIN_W-1] = wmsb;
      if (hit_xg) next_cal.x_gain[aogc_pkg::BYTE_W-1:0] = wbyte;
      // Y gain top bit and low byte
      if (hit_yoh) next_cal.y_gain[aogc_pkg::GAIN_W-1] = wmsb;
      if (hit_yg) next_cal.y_gain[aogc_pkg::BYTE_W-1:0] = wbyte;
      // Z gain top bit in bit 7 of the Z high byte
      if (hit_zoh) next_cal.z_gain[aogc_pkg::GAIN_W-1] = wmsb;
      if (hit_zg) next_cal.z_gain[aogc_pkg::BYTE_W-1:0] = wbyte;
    end
  end

  // Factory set taken at reset; a sync reset may sample the port
  always_ff @(posedge clk) begin
    if (sys_rst) cal <= factory_cal;
    else if (ce) cal <= next_cal;
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Calibration bytes are write only and read back as zero
  wire logic [aogc_pkg::DATA_W-1:0] rd_mux =
    hit_ox ? aogc_pkg::DATA_W'({1'b0, out_x}) & ((aogc_pkg::DATA_W'(1) << OUT_W) - 1) :
    hit_oy ? aogc_pkg::DATA_W'({1'b0, out_y}) & ((aogc_pkg::DATA_W'(1) << OUT_W) - 1) :
    hit_oz ? aogc_pkg::DATA_W'({1'b0, out_z}) & ((aogc_pkg::DATA_W'(1) << OUT_W) - 1) :
    '0;

  // Read data register, loaded in the first access cycle
  always_ff @(posedge clk) begin
    if (sys_rst) prdata <= '0;
    else if (rd_cap) prdata <= rd_mux;
  end

  // ----------------------------------------------------------------
  // Sample path
  // ----------------------------------------------------------------
  logic vld_x;
  logic vld_y;
  logic vld_z;

  aogc_axis_cal #(.IN_W(IN_W), .OUT_W(OUT_W)) u_cal_x (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .in_valid(raw_valid),
    .in_data(raw_x),
    .offset(signed'(cal.x_off)),
    .gain(cal.x_gain),
    .out_valid(vld_x),
    .out_data(out_x)
  );

  // Gain enters each axis as an unsigned 9-bit factor
  aogc_axis_cal #(.IN_W(IN_W), .OUT_W(OUT_W)) u_cal_y (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .in_valid(raw_valid),
    .in_data(raw_y),
    .offset(signed'(cal.y_off)),
    .gain(cal.y_gain),
    .out_valid(vld_y),
    .out_data(out_y)
  );

  // Z offset added before the result reaches the output registers
  aogc_axis_cal #(.IN_W(IN_W), .OUT_W(OUT_W)) u_cal_z (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .in_valid(raw_valid),
    .in_data(raw_z),
    .offset(signed'(cal.z_off)),
    .gain(cal.z_gain),
    .out_valid(vld_z),
    .out_data(out_z)
  );

  // All lanes share one valid; the others are equal by construction
  assign out_valid = vld_x && vld_y && vld_z;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Helper: expected Z result at unity gain, no clamp reached
  localparam logic [aogc_pkg::GAIN_W-1:0] UNITY = aogc_pkg::GAIN_W'(1 << aogc_pkg::GAIN_SHIFT);
  wire logic signed [OUT_W:0] z_exp = (OUT_W + 1)'(raw_z) + (OUT_W + 1)'(signed'(cal.z_off));
  wire logic z_fits = (z_exp[OUT_W] == z_exp[OUT_W-1]);

  sequence s_wr(logic [aogc_pkg::IDX_W-1:0] idx);
    wr_fire && hit_cal && (reg_idx == idx);
  endsequence

  sequence s_unity_z;
    ce && raw_valid && (cal.z_gain == UNITY) && z_fits;
  endsequence

  a_z_offset_add: assert property (@(posedge clk) disable iff (sys_rst)
    s_unity_z |=> out_valid && (out_z == OUT_W'($past(z_exp))))
    else $error("Z output is not sample plus offset");

  a_factory_load: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(sys_rst) |-> (cal == $past(factory_cal)))
    else $error("Calibration not loaded from factory set at reset");

  a_reload_factory: assert property (@(posedge clk) disable iff (sys_rst)
    reload |=> (cal == $past(factory_cal)))
    else $error("Reload did not restore factory set");

  // Z offset low and high bytes
  a_z_off_bytes: assert property (@(posedge clk) disable iff (sys_rst)
    s_wr(aogc_pkg::IDX_Z_OFF_HI) |=>
      (cal.z_off[aogc_pkg::OFF_W-1:aogc_pkg::BYTE_W] == $past(whi)) &&
      (cal.z_off[aogc_pkg::BYTE_W-1:0] == $past(cal.z_off[aogc_pkg::BYTE_W-1:0])))
    else $error("Z offset high byte misplaced");

  // Z gain top bit from the shared byte
  a_z_gain_msb: assert property (@(posedge clk) disable iff (sys_rst)
    s_wr(aogc_pkg::IDX_Z_OFF_HI) |=> (cal.z_gain[aogc_pkg::GAIN_W-1] == $past(wmsb)))
    else $error("Z gain top bit not taken from bit 7");

  // Z gain low byte is write only
  a_z_gain_wo: assert property (@(posedge clk) disable iff (sys_rst)
    rd_cap && hit_zg ##1 pready |-> (prdata == '0))
    else $error("Z gain byte read back non-zero");

  // X gain assembled from two registers
  a_x_gain_pair: assert property (@(posedge clk) disable iff (sys_rst)
    s_wr(aogc_pkg::IDX_X_GAIN_LO) |=>
      (cal.x_gain == {$past(cal.x_gain[aogc_pkg::GAIN_W-1]), $past(wbyte)}))
    else $error("X gain low byte misplaced");

  // Y gain top bit from the Y high byte
  a_y_gain_msb: assert property (@(posedge clk) disable iff (sys_rst)
    s_wr(aogc_pkg::IDX_Y_OFF_HI) |=> (cal.y_gain[aogc_pkg::GAIN_W-1] == $past(wmsb)))
    else $error("Y gain top bit not taken from bit 7");

  a_x_off_low: assert property (@(posedge clk) disable iff (sys_rst)
    s_wr(aogc_pkg::IDX_X_OFF_LO) |=> (cal.x_off[aogc_pkg::BYTE_W-1:0] == $past(wbyte)))
    else $error("X offset low byte misplaced");

  a_gain_scale: assert property (@(posedge clk) disable iff (sys_rst)
    ce && raw_valid && (cal.x_gain == '0) |=> (out_x == '0))
    else $error("Zero gain did not zero X output");

  // Short names for the field edges used below
  localparam int BW = aogc_pkg::BYTE_W;
  localparam int OW = aogc_pkg::OFF_W;
  localparam int GW = aogc_pkg::GAIN_W;

  // Helper: X sum before scaling; its sign must survive an unsigned gain
  wire logic signed [OUT_W:0] x_sum = (OUT_W + 1)'(raw_x) + (OUT_W + 1)'(signed'(cal.x_off));

  // A sample taken while the block runs
  sequence s_take;
    ce && raw_valid;
  endsequence

  // Z offset low byte leaves the high bits alone
  a_z_off_low: assert property (@(posedge clk) disable iff (sys_rst)
    s_wr(aogc_pkg::IDX_Z_OFF_LO) |=>
      (cal.z_off[BW-1:0] == $past(wbyte)) &&
      (cal.z_off[OW-1:BW] == $past(cal.z_off[OW-1:BW])))
    else $error("Z offset low byte misplaced");

  // Z gain low byte keeps the top bit
  a_z_gain_low: assert property (@(posedge clk) disable iff (sys_rst)
    s_wr(aogc_pkg::IDX_Z_GAIN_LO) |=>
      (cal.z_gain == {$past(cal.z_gain[GW-1]), $past(wbyte)}))
    else $error("Z gain low byte misplaced");

  // X gain top bit from the X high byte
  a_x_gain_msb: assert property (@(posedge clk) disable iff (sys_rst)
    s_wr(aogc_pkg::IDX_X_OFF_HI) |=> (cal.x_gain[GW-1] == $past(wmsb)))
    else $error("X gain top bit not taken from bit 7");

  // X offset upper seven bits share the X high byte
  a_x_off_high: assert property (@(posedge clk) disable iff (sys_rst)
    s_wr(aogc_pkg::IDX_X_OFF_HI) |=>
      (cal.x_off[OW-1:BW] == $past(whi)) &&
      (cal.x_off[BW-1:0] == $past(cal.x_off[BW-1:0])))
    else $error("X offset high bits misplaced");

  // Y gain low byte keeps the top bit
  a_y_gain_low: assert property (@(posedge clk) disable iff (sys_rst)
    s_wr(aogc_pkg::IDX_Y_GAIN_LO) |=>
      (cal.y_gain == {$past(cal.y_gain[GW-1]), $past(wbyte)}))
    else $error("Y gain low byte misplaced");

  // A gain with its top bit set never turns a positive sum negative
  a_gain_unsigned: assert property (@(posedge clk) disable iff (sys_rst)
    ce && raw_valid && cal.x_gain[GW-1] && !x_sum[OUT_W] |=> !out_x[OUT_W-1])
    else $error("X gain treated as signed");

  // Every taken sample shows one cycle later
  a_sample_valid: assert property (@(posedge clk) disable iff (sys_rst)
    s_take |=> out_valid)
    else $error("Sample result did not appear");

  // No result without a taken sample
  a_no_ghost: assert property (@(posedge clk) disable iff (sys_rst)
    ce && !raw_valid |=> !out_valid)
    else $error("Result appeared without a sample");

  // Calibration changes only at a completing write
  a_no_early_write: assert property (@(posedge clk) disable iff (sys_rst)
    !pready |=> $stable(cal))
    else $error("Calibration changed outside a write");

  // A refused access leaves the calibration as it was
  a_refused_keep: assert property (@(posedge clk) disable iff (sys_rst)
    pslverr |=> $stable(cal))
    else $error("Refused access changed the calibration");

  // An error is only ever flagged together with ready
  a_err_ready: assert property (@(posedge clk) disable iff (sys_rst)
    pslverr |-> pready)
    else $error("Error flagged outside the access phase");

  // A low clock enable freezes registers and results
  a_ce_freeze: assert property (@(posedge clk) disable iff (sys_rst)
    !ce |=> $stable(cal) && $stable(prdata) && $stable(out_z) && $stable(out_valid))
    else $error("State moved while the clock enable was low");

  // Bus answers after exactly one wait state
  a_apb_one_wait: assert property (@(posedge clk) disable iff (sys_rst)
    access && !ack_q && ce |=> pready || !ce)
    else $error("APB answer did not follow one wait state");

endmodule : aogc_top

// ### bench/aogc_top_tb.sv
// Self-checking testbench of the calibration register bank
`timescale 1ns/1ps

module aogc_top_tb;
  // ------------------------------------------------------------
  // Signals and scoreboard state
  // ------------------------------------------------------------
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  aogc_pkg::aogc_cal_t factory_cal = '0;
  aogc_pkg::aogc_cal_t cal_m;
  logic raw_valid = 1'b0;
  logic signed [13:0] raw_x = 14'h0000;
  logic signed [13:0] raw_y = 14'h0000;
  logic signed [13:0] raw_z = 14'h0000;
  logic out_valid;
  logic signed [15:0] out_x, out_y, out_z;
  logic [47:0] samp_q[$];
  logic [32:0] apb_q[$];
  logic [47:0] se, last_s;
  logic [32:0] ae;
  logic [31:0] rnd = 32'h0000_0006;
  int err_total = 0;
  int compares = 0;

  // 50 ns period
  always #25 clk = ~clk;

  aogc_top aogc_top_inst (.clk(clk), .sys_rst(sys_rst), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .factory_cal(factory_cal),
    .raw_valid(raw_valid), .raw_x(raw_x), .raw_y(raw_y), .raw_z(raw_z),
    .out_valid(out_valid), .out_x(out_x), .out_y(out_y), .out_z(out_z));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // Wide signed math so that saturation is judged before truncation
  function automatic logic [15:0] calc(input logic signed [13:0] r,
    input logic signed [14:0] o, input logic [8:0] g);
    longint s;
    s = ((longint'(r) + longint'(o)) * longint'({1'b0, g})) >>> 8;
    if (s > 32767) s = 32767;
    if (s < -32768) s = -32768;
    return s[15:0];
  endfunction : calc

  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict

  // Leaves psel high so a following call is a back-to-back setup
  task automatic apb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
    input logic [3:0] st, input logic [31:0] erd, input logic eerr);
    int n;
    apb_q.push_back({erd, eerr});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    pstrb <= st;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
  endtask : apb_xfer

  task automatic apb_idle();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb_idle

  task automatic wr_reg(input logic [7:0] idx, input logic [7:0] b);
    apb_xfer(1'b1, {2'b00, idx, 2'b00}, {24'h00_0000, b}, 4'hf, 32'h0000_0000, 1'b0);
    case (idx)
      8'h2a: cal_m.x_off[7:0] = b;
      8'h2b: {cal_m.x_gain[8], cal_m.x_off[14:8]} = b;
      8'h2c: cal_m.y_off[7:0] = b;
      8'h2d: {cal_m.y_gain[8], cal_m.y_off[14:8]} = b;
      8'h2e: cal_m.z_off[7:0] = b;
      8'h2f: {cal_m.z_gain[8], cal_m.z_off[14:8]} = b;
      8'h30: cal_m.x_gain[7:0] = b;
      8'h31: cal_m.y_gain[7:0] = b;
      8'h32: cal_m.z_gain[7:0] = b;
      aogc_pkg::IDX_CAL_CTRL: if (b[0]) cal_m = factory_cal;
      default: ;
    endcase
  endtask : wr_reg

  // Consecutive samples, raw_valid held high across the burst
  task automatic send_burst(input int n);
    logic signed [13:0] rx, ry, rz;
    raw_valid <= 1'b1;
    for (int i = 0; i < n; i++) begin
      rnd = lfsr(lfsr(rnd));
      rx = rnd[13:0];
      ry = rnd[27:14];
      rnd = lfsr(rnd);
      rz = rnd[13:0];
      raw_x <= rx;
      raw_y <= ry;
      raw_z <= rz;
      last_s = {calc(rx, cal_m.x_off, cal_m.x_gain), calc(ry, cal_m.y_off, cal_m.y_gain),
        calc(rz, cal_m.z_off, cal_m.z_gain)};
      samp_q.push_back(last_s);
      @(posedge clk);
    end
    raw_valid <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : send_burst

  task automatic new_factory();
    rnd = lfsr(rnd);
    factory_cal[71:40] <= rnd;
    rnd = lfsr(rnd);
    factory_cal[39:8] <= rnd;
    rnd = lfsr(rnd);
    factory_cal[7:0] <= rnd[7:0];
  endtask : new_factory

  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask : end_test

  // ------------------------------------------------------------
  // Monitor: pops the oldest note whenever a result shows
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (!sys_rst && ce && out_valid === 1'b1) begin
      se = (samp_q.size() > 0) ? samp_q.pop_front() : 48'hxxxx_xxxx_xxxx;
      check({32'h0000_0000, out_x}, {32'h0000_0000, se[47:32]});
      check({32'h0000_0000, out_y}, {32'h0000_0000, se[31:16]});
      check({32'h0000_0000, out_z}, {32'h0000_0000, se[15:0]});
    end
    if (!sys_rst && psel && penable && pready === 1'b1) begin
      ae = (apb_q.size() > 0) ? apb_q.pop_front() : 33'h1_ffff_ffff;
      check({47'h0, pslverr}, {47'h0, ae[0]});
      if (!pwrite) check({16'h0000, prdata}, {16'h0000, ae[32:1]});
    end
  end

  // ------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    print_verdict();
  end

  initial begin
    new_factory();
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    cal_m = factory_cal;
    @(posedge clk);
    // factory set in force after reset
    send_burst(4);
    end_test("factory");
    // every calibration byte rewritten, gain MSB set then clear
    for (int p = 0; p < 2; p++) begin
      for (int i = 8'h2a; i <= 8'h32; i++) begin
        rnd = lfsr(rnd);
        wr_reg(8'(i), (i == 8'h2b || i == 8'h2d || i == 8'h2f) ?
          {p == 0, rnd[6:0]} : rnd[7:0]);
      end
      apb_idle();
      send_burst(3);
    end
    end_test("writes");
    // unity Z gain passes the offset through, zero X gain blanks X
    wr_reg(8'h2f, {1'b1, cal_m.z_off[14:8]});
    wr_reg(8'h32, 8'h00);
    wr_reg(8'h2b, {1'b0, cal_m.x_off[14:8]});
    wr_reg(8'h30, 8'h00);
    apb_idle();
    send_burst(3);
    end_test("unity");
    // calibration bytes are write only and read as zero
    for (int i = 8'h2a; i <= 8'h32; i++) begin
      apb_xfer(1'b0, {2'b00, 8'(i), 2'b00}, 32'h0000_0000, 4'h0, 32'h0000_0000, 1'b0);
    end
    apb_xfer(1'b0, 12'h100, 32'h0000_0000, 4'h0, 32'h0000_0000, 1'b0);
    end_test("reads");
    // Refused and ignored accesses leave the calibration untouched
    apb_xfer(1'b1, 12'h0b8, 32'h0000_00a5, 4'he, 32'h0000_0000, 1'b0);
    apb_xfer(1'b1, 12'h040, 32'h0000_00a5, 4'hf, 32'h0000_0000, 1'b1);
    apb_xfer(1'b0, 12'h0fc, 32'h0000_0000, 4'h0, 32'h0000_0000, 1'b1);
    apb_xfer(1'b1, 12'h0b9, 32'h0000_00a5, 4'hf, 32'h0000_0000, 1'b1);
    apb_xfer(1'b1, 12'h4b8, 32'h0000_00a5, 4'hf, 32'h0000_0000, 1'b1);
    apb_xfer(1'b1, 12'h10c, 32'h0000_00a5, 4'hf, 32'h0000_0000, 1'b0);
    apb_idle();
    send_burst(2);
    end_test("refusals");
    // Result readback, with ce dropped during one access to stretch it
    apb_xfer(1'b0, 12'h104, 32'h0000_0000, 4'h0, {16'h0000, last_s[47:32]}, 1'b0);
    apb_xfer(1'b0, 12'h108, 32'h0000_0000, 4'h0, {16'h0000, last_s[31:16]}, 1'b0);
    fork
      apb_xfer(1'b0, 12'h10c, 32'h0000_0000, 4'h0, {16'h0000, last_s[15:0]}, 1'b0);
      begin
        @(posedge clk);
        ce <= 1'b0;
        repeat (3) @(posedge clk);
        ce <= 1'b1;
      end
    join
    apb_idle();
    end_test("outputs");
    // reload from a changed factory set
    new_factory();
    @(posedge clk);
    wr_reg(aogc_pkg::IDX_CAL_CTRL, 8'h01);
    apb_idle();
    send_burst(3);
    end_test("reload");
    // second reset picks up the new factory set and clears results
    new_factory();
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    cal_m = factory_cal;
    @(posedge clk);
    check({31'h0, out_valid, out_z}, 48'h0);
    send_burst(2);
    end_test("reset");
    check(48'(samp_q.size() + apb_q.size()), 48'h0);
    print_verdict();
  end
endmodule : aogc_top_tb
